// ===== hdl/spc_group.sv
// Power resolution for one MAC group of four serial ports.
// Assumes the caller hands in the already overridden controls of the group.
`timescale 1ns/10ps
module spc_group
   import spc_pkg::*;
(
   input wire spc_grp_cfg_s cfg,
   output spc_grp_stat_s stat
);

   // True when every port of the group asks to be powered down.
   wire all_down;
   // Secondary lane controls as they reach lanes B, C and D.
   wire [2:0] sec_lane_pd;

   assign all_down = cfg.pri_pd & (&cfg.sec_pd);

   // In four-lane mode the primary control drives every lane together.
   // In single-lane mode lanes B, C, D follow their own secondary ports.
   assign sec_lane_pd = cfg.single_lane ? cfg.sec_pd : {3{cfg.pri_pd}};
   assign stat.lane_pd = {sec_lane_pd, cfg.pri_pd};

   // The block only shuts down when it no longer serves any lane.
   assign stat.block_pd = cfg.single_lane ? all_down : cfg.pri_pd;

   // Primary port state follows its control directly.
   assign stat.pri_pd = cfg.pri_pd;

   // Secondaries honour their controls in either mode, so an idle one can be shut down.
   assign stat.sec_pd = cfg.sec_pd;

   // Secondaries carry traffic only in single-lane mode and while powered.
   assign stat.sec_active = cfg.single_lane ? ~cfg.sec_pd : 3'h0;

endmodule // spc_group

// ===== hdl/spc_pkg.sv
// Constants and carrier types for the serial port strap and power configuration block.
// Assumes one clock and a synchronous, active-high reset that is held while the straps settle.
// Notes on behaviour
// - One width strap per group 0,2,4,6.
// - Strap 0 four-lane port, 1 four single-lane.
// - Width override field beats the width strap.
// - Primary power-down straps exist for 2,4,6 only.
// - Four-lane primary power-down governs lanes A-D.
// - Single-lane secondaries powered by own controls.
// - Secondaries of primary x are x+1,x+8,x+9.
// - Single-lane, all four down: transceiver block down.
// - Primary control 0 up, 1 down.
// - Secondary straps ports 1,3,5,7-15; 1 means down.
// - Four-lane secondaries idle, may be powered down.
// - Wide power-down field overrides primary strap.
// - Narrow power-down field overrides secondary straps.
// - Strap pins drive out only in test mode.
// - Single-lane lanes A,B,C,D serve x,x+1,x+8,x+9.
package spc_pkg;

   // Number of MAC groups, of secondary ports in each one, and of ports in all.
   localparam int SPC_GROUPS = 4;
   localparam int SPC_SEC_PER_GROUP = 3;
   localparam int SPC_PORTS = 16;

   // Offsets from a group's primary port to its secondaries, lanes B, C and D in that order.
   localparam int SPC_SEC_OFS_B = 1;
   localparam int SPC_SEC_OFS_C = 8;
   localparam int SPC_SEC_OFS_D = 9;

   // Primary port number of group g is g times this stride: 0, 2, 4, 6.
   localparam int SPC_PRI_STRIDE = 2;

   // Group 0 has no primary power-down strap; its field comes out of reset at this level.
   localparam logic SPC_PORT0_PD_RST = 1'h0;

   // Resolved outputs while reset is held: every lane and block down, no port active.
   localparam logic [3:0] SPC_SINGLE_RST = 4'h0;
   localparam logic [15:0] SPC_LANE_PD_RST = 16'hffff;
   localparam logic [3:0] SPC_SERDES_PD_RST = 4'hf;
   localparam logic [15:0] SPC_PORT_PD_RST = 16'h0000;
   localparam logic [15:0] SPC_ACTIVE_RST = 16'h0000;

   // Width strap encoding.
   localparam logic SPC_WIDTH_FOUR_LANE = 1'h0;
   localparam logic SPC_WIDTH_SINGLE_LANE = 1'h1;

   // Power-down control encoding.
   localparam logic SPC_PD_UP = 1'h0;
   localparam logic SPC_PD_DOWN = 1'h1;

   // Lane positions inside a group's transceiver block.
   localparam int SPC_LANE_A = 0;
   localparam int SPC_LANE_B = 1;
   localparam int SPC_LANE_C = 2;
   localparam int SPC_LANE_D = 3;

   // Effective configuration of one group.
   typedef struct packed {
      logic single_lane;          // 1 when the group runs four single-lane ports.
      logic pri_pd;               // Primary port power-down control.
      logic [2:0] sec_pd;         // Secondary power-down controls, lanes B, C, D.
   } spc_grp_cfg_s;

   // Resolved power state of one group.
   typedef struct packed {
      logic [3:0] lane_pd;        // Per-lane power-down, lane A in bit 0.
      logic block_pd;             // Whole transceiver block powered down.
      logic pri_pd;               // Primary port powered down.
      logic [2:0] sec_pd;         // Secondary ports powered down.
      logic [2:0] sec_active;     // Secondary ports that may carry traffic.
   } spc_grp_stat_s;

endpackage

// ===== hdl/spc_strap_cfg.sv
// Top of the serial port strap and power configuration block.
// Straps are sampled at reset release; override fields are plain ports written by a strobe.
// Assumes straps are stable and synchronous to clock while rst is high.
// Limitation: the group count is fixed at four by the port widths.
`timescale 1ns/10ps
module spc_strap_cfg
   import spc_pkg::*;
#(
   parameter int GROUPS = SPC_GROUPS
)
(
   input wire logic clock,
   input wire logic rst,
   // Width strap pins, one per group, input side.
   input wire logic [3:0] group_width_strap_in,
   // Width strap pins, output side and enable, test mode only.
   output logic [3:0] group_width_strap_out,
   output logic [3:0] group_width_strap_oe,
   // Primary power-down strap pins for ports 2, 4, 6; bit g-1 serves group g.
   input wire logic [2:0] primary_port_powerdown_strap_in,
   output logic [2:0] primary_port_powerdown_strap_out,
   output logic [2:0] primary_port_powerdown_strap_oe,
   // Secondary power-down strap pins; bit g*3+k is lane B, C, D of group g.
   input wire logic [11:0] secondary_port_powerdown_strap_in,
   output logic [11:0] secondary_port_powerdown_strap_out,
   output logic [11:0] secondary_port_powerdown_strap_oe,
   // Test mode and the levels driven onto the strap pins while in it.
   input wire logic test_mode,
   input wire logic [3:0] test_width_drive,
   input wire logic [2:0] test_primary_drive,
   input wire logic [11:0] test_secondary_drive,
   // Override field writes.
   input wire logic group_width_override_wr,
   input wire logic [3:0] group_width_override_wdata,
   input wire logic wide_port_powerdown_override_wr,
   input wire logic [3:0] wide_port_powerdown_override_wdata,
   input wire logic narrow_port_powerdown_override_wr,
   input wire logic [11:0] narrow_port_powerdown_override_wdata,
   // Override field read-back.
   output logic [3:0] group_width_override,
   output logic [3:0] wide_port_powerdown_override,
   output logic [11:0] narrow_port_powerdown_override,
   // Raw strap levels caught at reset release.
   output logic [3:0] sampled_at_power_up_width,
   output logic [15:0] sampled_at_power_up_powerdown,
   // Resolved state towards the MAC and the transceivers.
   output logic [3:0] group_single_lane,
   output logic [15:0] lane_powerdown,
   output logic [3:0] serdes_powerdown,
   output logic [15:0] primary_port_powerdown,
   output logic [15:0] secondary_port_powerdown,
   output logic [15:0] port_active
);

   // Override fields.
   logic [3:0] width_ovr_ff;
   logic [3:0] wide_pd_ovr_ff;
   logic [11:0] narrow_pd_ovr_ff;
   // Raw strap captures: width per group, power-down per port number.
   logic [3:0] smp_width_ff;
   logic [15:0] smp_pd_ff;
   // Registered resolved outputs.
   logic [3:0] single_ff;
   logic [15:0] lane_pd_ff;
   logic [3:0] serdes_pd_ff;
   logic [15:0] pri_pd_ff;
   logic [15:0] sec_pd_ff;
   logic [15:0] active_ff;
   // Next values of the resolved outputs.
   logic [15:0] nxt_lane_pd;
   logic [3:0] nxt_serdes_pd;
   logic [15:0] nxt_pri_pd;
   logic [15:0] nxt_sec_pd;
   logic [15:0] nxt_active;
   // Straps rearranged per port number.
   logic [15:0] strap_pd_by_port;
   // Primary strap of each group, group 0 taking the fixed default.
   wire [3:0] pri_strap = {primary_port_powerdown_strap_in, SPC_PORT0_PD_RST};

   // Strap pins only drive while the test mode is active.
   // Outside test mode the drivers are off and the levels forced low, so a board
   // tie-off never fights the device and the idle output stays at a known value.
   assign group_width_strap_oe = {4{test_mode}};
   assign primary_port_powerdown_strap_oe = {3{test_mode}};
   assign secondary_port_powerdown_strap_oe = {12{test_mode}};
   assign group_width_strap_out = test_mode ? test_width_drive : 4'h0;
   assign primary_port_powerdown_strap_out = test_mode ? test_primary_drive : 3'h0;
   assign secondary_port_powerdown_strap_out = test_mode ? test_secondary_drive : 12'h0;

   // Spread the strap bits onto port numbers; port 0 carries no strap of its own.
   always_comb begin
      // Default every port to powered up, then fill in the strapped ones.
      strap_pd_by_port = 16'h0000;
      for (int g = 0; g < SPC_GROUPS; g++) begin
         // Primary port of the group, then its three secondaries on lanes B, C and D.
         strap_pd_by_port[g * SPC_PRI_STRIDE] = pri_strap[g];
         strap_pd_by_port[g * SPC_PRI_STRIDE + SPC_SEC_OFS_B] = secondary_port_powerdown_strap_in[g * 3];
         strap_pd_by_port[g * SPC_PRI_STRIDE + SPC_SEC_OFS_C] = secondary_port_powerdown_strap_in[g * 3 + 1];
         strap_pd_by_port[g * SPC_PRI_STRIDE + SPC_SEC_OFS_D] = secondary_port_powerdown_strap_in[g * 3 + 2];
      end
   end

   // Straps are followed throughout reset and frozen on release, so the board
   // only needs them steady around the release edge.
   // A strap that glitches at that last edge is caught as it is; there is no filtering.
   always_ff @(posedge clock) begin
      if (rst) begin
         // Reset edge: track the pins, the last such edge wins.
         smp_width_ff <= group_width_strap_in;
         smp_pd_ff <= strap_pd_by_port;
      end
      // Out of reset the captures hold, so later strap changes are ignored.
   end

   // Width field: defaults to the strap, a write replaces it.
   always_ff @(posedge clock) begin
      if (rst) begin
         // Reset: the strap level becomes the field default.
         width_ovr_ff <= group_width_strap_in;
      end else if (group_width_override_wr) begin
         // A write replaces the whole field at once.
         width_ovr_ff <= group_width_override_wdata;
      end
   end

   // Wide power-down field stands in for the primary straps.
   always_ff @(posedge clock) begin
      if (rst) begin
         // Reset: the primary straps become the field default.
         wide_pd_ovr_ff <= pri_strap;
      end else if (wide_port_powerdown_override_wr) begin
         // A write replaces the whole field at once.
         wide_pd_ovr_ff <= wide_port_powerdown_override_wdata;
      end
   end

   // Narrow power-down field stands in for the secondary straps.
   always_ff @(posedge clock) begin
      if (rst) begin
         // Reset: the secondary straps become the field default.
         narrow_pd_ovr_ff <= secondary_port_powerdown_strap_in;
      end else if (narrow_port_powerdown_override_wr) begin
         // A write replaces the whole field at once.
         narrow_pd_ovr_ff <= narrow_port_powerdown_override_wdata;
      end
   end

   // One resolver per group; the resolved state is only taken from the fields,
   // never from the pins, so software always has the last word.
   spc_grp_stat_s grp_stat [GROUPS]; // Per-group result, one entry per resolver.
   for (genvar g = 0; g < GROUPS; g++) begin : g_grp
      // Controls of this group as the fields currently hold them.
      spc_grp_cfg_s cfg;
      assign cfg.single_lane = (width_ovr_ff[g] == SPC_WIDTH_SINGLE_LANE);
      assign cfg.pri_pd = wide_pd_ovr_ff[g];
      assign cfg.sec_pd = narrow_pd_ovr_ff[g * 3 +: 3];
      spc_group u_group (
         .cfg(cfg),
         .stat(grp_stat[g])
      );
   end

   // Map each group's result back onto port and lane numbers.
   always_comb begin
      nxt_lane_pd = 16'h0000;
      nxt_serdes_pd = 4'h0;
      nxt_pri_pd = 16'h0000;
      nxt_sec_pd = 16'h0000;
      nxt_active = 16'h0000;
      for (int g = 0; g < GROUPS; g++) begin
         // Lanes and block of this group's transceiver.
         nxt_lane_pd[g * 4 +: 4] = grp_stat[g].lane_pd;
         nxt_serdes_pd[g] = grp_stat[g].block_pd;
         nxt_pri_pd[g * SPC_PRI_STRIDE] = grp_stat[g].pri_pd;
         // A primary carries traffic whenever it is powered.
         nxt_active[g * SPC_PRI_STRIDE] = ~grp_stat[g].pri_pd;
         // Secondary ports sit at offsets 1, 8 and 9 from the primary.
         nxt_sec_pd[g * SPC_PRI_STRIDE + SPC_SEC_OFS_B] = grp_stat[g].sec_pd[0];
         nxt_sec_pd[g * SPC_PRI_STRIDE + SPC_SEC_OFS_C] = grp_stat[g].sec_pd[1];
         nxt_sec_pd[g * SPC_PRI_STRIDE + SPC_SEC_OFS_D] = grp_stat[g].sec_pd[2];
         nxt_active[g * SPC_PRI_STRIDE + SPC_SEC_OFS_B] = grp_stat[g].sec_active[0];
         nxt_active[g * SPC_PRI_STRIDE + SPC_SEC_OFS_C] = grp_stat[g].sec_active[1];
         nxt_active[g * SPC_PRI_STRIDE + SPC_SEC_OFS_D] = grp_stat[g].sec_active[2];
      end
   end

   // Resolved outputs are registered; during reset every lane and block is held powered down
   // so no lane wakes before the straps have been caught.
   always_ff @(posedge clock) begin
      if (rst) begin
         // Reset: every lane and block down, no port may carry traffic.
         single_ff <= SPC_SINGLE_RST;
         lane_pd_ff <= SPC_LANE_PD_RST;
         serdes_pd_ff <= SPC_SERDES_PD_RST;
         pri_pd_ff <= SPC_PORT_PD_RST;
         sec_pd_ff <= SPC_PORT_PD_RST;
         active_ff <= SPC_ACTIVE_RST;
      end else begin
         // Running: take the resolved state one cycle behind the fields.
         single_ff <= width_ovr_ff;
         lane_pd_ff <= nxt_lane_pd;
         serdes_pd_ff <= nxt_serdes_pd;
         pri_pd_ff <= nxt_pri_pd;
         sec_pd_ff <= nxt_sec_pd;
         active_ff <= nxt_active;
      end
   end

   // Read-back and status.
   // These are plain wires off the registers, so they add no delay of their own.
   assign group_width_override = width_ovr_ff;
   assign wide_port_powerdown_override = wide_pd_ovr_ff;
   assign narrow_port_powerdown_override = narrow_pd_ovr_ff;
   assign sampled_at_power_up_width = smp_width_ff;
   assign sampled_at_power_up_powerdown = smp_pd_ff;
   assign group_single_lane = single_ff;
   assign lane_powerdown = lane_pd_ff;
   assign serdes_powerdown = serdes_pd_ff;
   assign primary_port_powerdown = pri_pd_ff;
   assign secondary_port_powerdown = sec_pd_ff;
   assign port_active = active_ff;

endmodule // spc_strap_cfg

// ===== test/spc_board_straps.sv
// Board tie-off model for the strap pins: width, primary and secondary levels in one vector.
// Assumes the bench loads new levels only between resets; test-mode drive wins on the wire.
`timescale 1ns/10ps
module spc_board_straps (
   input wire logic clock,
   input wire logic load,
   input wire logic [18:0] level,
   input wire logic [18:0] drv_out,
   input wire logic [18:0] drv_oe,
   output logic [18:0] pin
);
   logic [18:0] tie_ff; // Held tie-off levels.
   // The level stays put from one load to the next, so reset always sees it steady.
   always_ff @(posedge clock) begin
      if (load) begin
         tie_ff <= level;
      end
   end
   // A driven pin shows the device's level, otherwise the tie-off.
   assign pin = (drv_oe & drv_out) | (~drv_oe & tie_ff);
endmodule // spc_board_straps

// ===== test/spc_strap_cfg_bench.sv
// Self-checking bench for the strap and power configuration block.
// Assumes the board model feeds the strap pins and the checker is bound to the design.
`timescale 1ns/10ps
module spc_strap_cfg_bench
   import spc_pkg::*;
;
   logic clock, rst, test_mode, group_width_override_wr, wide_port_powerdown_override_wr, tie_load;
   logic narrow_port_powerdown_override_wr;
   logic [3:0] group_width_strap_in, group_width_strap_out, group_width_strap_oe, test_width_drive;
   logic [2:0] primary_port_powerdown_strap_in, primary_port_powerdown_strap_out, primary_port_powerdown_strap_oe;
   logic [11:0] secondary_port_powerdown_strap_in, secondary_port_powerdown_strap_out;
   logic [11:0] secondary_port_powerdown_strap_oe, test_secondary_drive, narrow_port_powerdown_override_wdata;
   logic [2:0] test_primary_drive;
   logic [11:0] narrow_port_powerdown_override, fs;
   logic [3:0] group_width_override_wdata, wide_port_powerdown_override_wdata, group_width_override, fw, fp;
   logic [3:0] wide_port_powerdown_override, sampled_at_power_up_width, group_single_lane, serdes_powerdown;
   logic [15:0] sampled_at_power_up_powerdown, lane_powerdown, primary_port_powerdown, secondary_port_powerdown;
   logic [15:0] port_active;
   logic [18:0] tie_level;
   logic [19:0] strap_seen; // Straps the device should have caught.
   logic [31:0] stim;
   logic [111:0] state_notes[$];
   logic [37:0] pin_notes[$];
   event ready;
   int seed = 25268;
   int bad_count = 0;
   int samples_checked = 0;
   spc_strap_cfg i_spc_strap_cfg (.*);
   spc_board_straps i_spc_board_straps (.clock(clock), .load(tie_load), .level(tie_level),
      .drv_out({group_width_strap_out, primary_port_powerdown_strap_out, secondary_port_powerdown_strap_out}),
      .drv_oe({group_width_strap_oe, primary_port_powerdown_strap_oe, secondary_port_powerdown_strap_oe}),
      .pin({group_width_strap_in, primary_port_powerdown_strap_in, secondary_port_powerdown_strap_in}));
   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   // Reference resolution: {mode, lanes, blocks, primaries, secondaries, active}.
   function automatic logic [71:0] resolve(input logic [3:0] w, input logic [3:0] p, input logic [11:0] s);
      logic [15:0] ln, pr, sc, ac;
      logic [3:0] sd;
      {ln, pr, sc, ac, sd} = '0;
      for (int g = 0; g < 4; g++) begin
         pr[2*g] = p[g];
         ac[2*g] = !p[g];
         ln[4*g] = p[g];
         sd[g] = w[g] ? p[g] & (&s[3*g+:3]) : p[g];
         for (int k = 0; k < 3; k++) begin
            sc[2*g+(k == 0 ? 1 : 7+k)] = s[3*g+k];
            ac[2*g+(k == 0 ? 1 : 7+k)] = w[g] & !s[3*g+k];
            ln[4*g+1+k] = w[g] ? s[3*g+k] : p[g];
         end
      end
      return {w, ln, sd, pr, sc, ac};
   endfunction
   task automatic note();
      state_notes.push_back({strap_seen, fw, fp, fs, resolve(fw, fp, fs)});
      pin_notes.push_back(test_mode ? {test_width_drive, test_primary_drive, test_secondary_drive, 19'h7_FFFF} : 38'h0);
      -> ready;
   endtask
   task automatic check_state(input logic [111:0] exp, input logic [111:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD state expected %h seen %h", exp, got);
      end
   endtask
   task automatic check_pins(input logic [37:0] exp, input logic [37:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD pins expected %h seen %h", exp, got);
      end
   endtask
   // Load new tie-offs, then hold reset for 8 cycles so the last sample is steady.
   task automatic do_reset(input logic [18:0] lvl);
      logic [71:0] r;
      r = resolve(4'h0, {lvl[14:12], SPC_PORT0_PD_RST}, lvl[11:0]);
      @(posedge clock);
      tie_level <= lvl;
      tie_load <= 1'h1;
      @(posedge clock);
      tie_load <= 1'h0;
      rst <= 1'h1;
      repeat (8) @(posedge clock);
      rst <= 1'h0;
      {fw, fp, fs} = {lvl[18:15], lvl[14:12], SPC_PORT0_PD_RST, lvl[11:0]};
      strap_seen = {lvl[18:15], r[47:32] | r[31:16]};
      @(posedge clock);
      note();
   endtask
   task automatic write_all(input logic [3:0] w, input logic [3:0] p, input logic [11:0] s);
      @(posedge clock);
      {group_width_override_wr, wide_port_powerdown_override_wr, narrow_port_powerdown_override_wr} <= 3'h7;
      group_width_override_wdata <= w;
      wide_port_powerdown_override_wdata <= p;
      narrow_port_powerdown_override_wdata <= s;
      {fw, fp, fs} = {w, p, s};
   endtask
   // Drop the strobes and note once the resolved outputs have caught up.
   task automatic settle();
      @(posedge clock);
      {group_width_override_wr, wide_port_powerdown_override_wr, narrow_port_powerdown_override_wr} <= 3'h0;
      @(posedge clock);
      note();
   endtask
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watcher: compares each result with the oldest note once it has settled.
   initial forever begin
      @(ready);
      @(negedge clock);
      check_state(state_notes.pop_front(), {
         sampled_at_power_up_width, sampled_at_power_up_powerdown, group_width_override,
         wide_port_powerdown_override, narrow_port_powerdown_override, group_single_lane, lane_powerdown,
         serdes_powerdown, primary_port_powerdown, secondary_port_powerdown, port_active});
      check_pins(pin_notes.pop_front(), {group_width_strap_out, primary_port_powerdown_strap_out,
         secondary_port_powerdown_strap_out, group_width_strap_oe, primary_port_powerdown_strap_oe,
         secondary_port_powerdown_strap_oe});
   end
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      end_sim();
   end
   initial begin
      {rst, tie_load, tie_level, test_mode, test_width_drive, test_primary_drive, test_secondary_drive} = '1;
      test_mode = 1'h0;
      tie_load = 1'h0;
      {group_width_override_wr, wide_port_powerdown_override_wr, narrow_port_powerdown_override_wr} = 3'h0;
      {group_width_override_wdata, wide_port_powerdown_override_wdata, narrow_port_powerdown_override_wdata} = '0;
      for (int run = 0; run < 2; run++) begin
         stim = $random(seed);
         do_reset(stim[18:0]);
         for (int i = 0; i < 18; i++) begin
            stim = $random(seed);
            write_all(stim[3:0], stim[7:4], stim[19:8]);
            if (stim[31]) write_all(stim[23:20], stim[27:24], stim[31:20]);
            settle();
         end
         // Whole blocks down in single-lane mode, then secondaries down under four-lane mode.
         write_all(4'hF, 4'hF, 12'hFFF);
         settle();
         write_all(4'h0, 4'h0, 12'hFFF);
         settle();
         // Test-mode drive, with the board changing its tie-offs after release.
         stim = $random(seed);
         @(posedge clock);
         test_mode <= 1'h1;
         {test_width_drive, test_primary_drive, test_secondary_drive} <= stim[18:0];
         tie_level <= ~tie_level;
         tie_load <= 1'h1;
         @(posedge clock);
         tie_load <= 1'h0;
         note();
         @(posedge clock);
         test_mode <= 1'h0;
         @(posedge clock);
         note();
      end
      repeat (2) @(posedge clock);
      end_sim();
   end
endmodule // spc_strap_cfg_bench

// ===== test/spc_strap_checker.sv
// Concurrent checks on the ports of the strap and power configuration top.
// Assumes one clock domain and a synchronous, active-high reset; bound below.
`timescale 1ns/10ps
module spc_strap_checker #(
   parameter int GROUPS = 4
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic test_mode,
   input wire logic [3:0] test_width_drive,
   input wire logic [3:0] group_width_strap_out,
   input wire logic [3:0] group_width_strap_oe,
   input wire logic [11:0] secondary_port_powerdown_strap_oe,
   input wire logic group_width_override_wr,
   input wire logic [3:0] group_width_override_wdata,
   input wire logic wide_port_powerdown_override_wr,
   input wire logic [3:0] wide_port_powerdown_override_wdata,
   input wire logic [3:0] group_width_override,
   input wire logic [3:0] wide_port_powerdown_override,
   input wire logic [3:0] group_single_lane,
   input wire logic [15:0] lane_powerdown,
   input wire logic [3:0] serdes_powerdown,
   input wire logic [15:0] primary_port_powerdown,
   input wire logic [15:0] port_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Pin drivers must stay off outside test mode, or they would fight the board tie-offs.
   a_pin_drive_enable: assert property (group_width_strap_oe == {4{test_mode}})
      else $error("width strap enable differs from test mode");
   a_pin_sec_enable: assert property (secondary_port_powerdown_strap_oe == {12{test_mode}})
      else $error("secondary strap enable differs from test mode");
   a_pin_drive_level: assert property (group_width_strap_out == (test_mode ? test_width_drive : 4'h0))
      else $error("width strap drive level wrong");
   a_width_write: assert property (group_width_override_wr |=>
      group_width_override == $past(group_width_override_wdata)) else $error("width field not written");
   a_wide_write: assert property (wide_port_powerdown_override_wr |=>
      wide_port_powerdown_override == $past(wide_port_powerdown_override_wdata)) else $error("wide field not written");
   a_width_hold: assert property (!group_width_override_wr |=> $stable(group_width_override))
      else $error("width field moved without a write");
   // Resolved outputs lag the fields by one cycle; the first cycle after reset still shows reset values.
   a_mode_follow: assert property (!$past(rst) |-> group_single_lane == $past(group_width_override))
      else $error("group mode does not follow width field");
   for (genvar g = 0; g < GROUPS; g++) begin : g_grp
      a_four_lane_pd: assert property (!$past(rst) && !group_single_lane[g] |->
         lane_powerdown[4*g+:4] == {4{primary_port_powerdown[2*g]}} && port_active[2*g+1] == 1'h0)
         else $error("four-lane group lanes or idle port wrong");
      a_block_pd: assert property (!$past(rst) |-> serdes_powerdown[g] ==
         (group_single_lane[g] ? &lane_powerdown[4*g+:4] : primary_port_powerdown[2*g]))
         else $error("transceiver block power-down wrong");
      a_pri_active: assert property (!$past(rst) |-> port_active[2*g] == !primary_port_powerdown[2*g])
         else $error("primary port activity wrong");
   end
   c_block_down: cover property (group_single_lane[0] && serdes_powerdown[0]);
   c_test_mode: cover property (test_mode);
   c_back_to_back: cover property (group_width_override_wr [*2]);
endmodule // spc_strap_checker

bind spc_strap_cfg spc_strap_checker #(.GROUPS(GROUPS)) i_spc_strap_checker (
   .clock(clock), .rst(rst), .test_mode(test_mode), .test_width_drive(test_width_drive),
   .group_width_strap_out(group_width_strap_out), .group_width_strap_oe(group_width_strap_oe),
   .secondary_port_powerdown_strap_oe(secondary_port_powerdown_strap_oe),
   .group_width_override_wr(group_width_override_wr), .group_width_override_wdata(group_width_override_wdata),
   .wide_port_powerdown_override_wr(wide_port_powerdown_override_wr),
   .wide_port_powerdown_override_wdata(wide_port_powerdown_override_wdata),
   .group_width_override(group_width_override), .wide_port_powerdown_override(wide_port_powerdown_override),
   .group_single_lane(group_single_lane), .lane_powerdown(lane_powerdown), .serdes_powerdown(serdes_powerdown),
   .primary_port_powerdown(primary_port_powerdown), .port_active(port_active)
);
